// File: verilog/rcm_core.sv
// reset-cause recording and boot memory remap logic
//////////////////////////////////////////////////////////////////////////////
// Function
// - program memory mirrored at zero after reset
// - vector region spans base up to 0x20
// - remap bit one mirrors sram at zero
// - remap bit zero mirrors program memory
// - remap selection reversible by software
// - system reset (rstn) clears remap selection; por_n alone leaves it
// - remap reversible, repeatable; once-only not enforced
// - reset starts factory code, then vector zero
// - factory code hidden from user code
// - four reset sources supported
// - all-zero cause means external pin reset
// - writing cause bit 2 in user phase forces software reset
// - watchdog timeout sets cause bit 1
// - power-on reset sets cause bit 0
// - cause flags cleared only by clear register and power-on reset
//////////////////////////////////////////////////////////////////////////////
module rcm_core
  import rcm_pkg::*;
#(
  parameter int unsigned FACTORY_CYC = 16
) (
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic              por_n,
  input  wire logic              wdt_timeout,
  input  wire logic              boot_select_pin,
  input  wire logic              factory_done,
  input  wire logic              user_access,
  input  wire logic [31:0]       fetch_addr,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  output logic                   sram_at_zero,
  output logic                   in_vector_region,
  output logic                   factory_active,
  output logic                   factory_blocked,
  output logic      [31:0]       start_addr,
  output logic                   start_pulse,
  output logic                   sw_reset_req,
  output logic                   irq
);

  //////////////////////////////////////////////////////////////////////////
  // decode helper, used for every register
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0]        ofs);
    hit = (a == ofs);
  endfunction

  rcm_req_s req;
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  wire wr_map   = req.wr & hit(req.addr, OFS_MAP_SEL);
  wire wr_cause = req.wr & hit(req.addr, OFS_CAUSE);
  wire wr_cclr  = req.wr & hit(req.addr, OFS_CAUSE_CLR);
  wire wr_iclr  = req.wr & hit(req.addr, OFS_IRQ_CLR);
  wire wr_ien   = req.wr & hit(req.addr, OFS_IRQ_EN);

  //////////////////////////////////////////////////////////////////////////
  // synchronise external levels (two flops each)
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= {boot_select_pin, wdt_timeout, factory_done};
      sync2_q <= sync1_q;
    end
  end
  wire boot_s  = sync2_q[2];
  wire wdt_s   = sync2_q[1];
  wire fdone_s = sync2_q[0];

  //////////////////////////////////////////////////////////////////////////
  // reset cause flags: kept on power-on domain only
  logic [CAUSE_W-1:0] cause_q;
  logic [CAUSE_W-1:0] cause_d;
  logic               wdt_seen_q;
  logic               swrst_fire;
  wire                wdt_rise = wdt_s & ~wdt_seen_q;

  always_comb begin
    cause_d = cause_q;
    // clear register only lowers flags
    if (wr_cclr) begin
      cause_d = cause_d & ~reg_wdata[CAUSE_W-1:0];
    end
    // set wins over a clear in the same cycle
    if (wdt_rise) begin
      cause_d[CAUSE_WDT_BIT] = 1'b1;
    end
    if (swrst_fire) begin
      cause_d[CAUSE_SW_BIT] = 1'b1;
    end
    cause_d[CAUSE_W-1:3] = '0;                       // reserved bits zero
  end

  // por_n resets these flags and the watchdog edge flag; rstn leaves them alone
  always_ff @(posedge sys_clk or negedge por_n) begin
    if (!por_n) begin
      cause_q <= 8'h01;
    end else begin
      cause_q <= cause_d;
    end
  end

  // watchdog edge detect, kept across system reset too
  always_ff @(posedge sys_clk or negedge por_n) begin
    if (!por_n) begin
      wdt_seen_q <= 1'b0;
    end else begin
      wdt_seen_q <= wdt_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // remap selection
  logic remap_q;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      remap_q <= REMAP_RST;
    end else if (wr_map) begin
      remap_q <= reg_wdata[REMAP_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // boot phase: factory code, user code, software reset request
  rcm_phase_e phase_q;
  rcm_phase_e phase_d;
  logic [SWRST_CNT_W-1:0] cnt_q;
  logic [SWRST_CNT_W-1:0] cnt_d;

  assign swrst_fire = wr_cause & reg_wdata[CAUSE_SW_BIT]
                      & (phase_q == ST_USER);

  always_comb begin
    phase_d = phase_q;
    cnt_d   = cnt_q;
    case (phase_q)
      ST_FACTORY: begin
        // leave factory code only in normal boot mode
        if (fdone_s && boot_s) begin
          phase_d = ST_USER;
        end
      end
      ST_USER: begin
        if (swrst_fire) begin
          phase_d = ST_SWRST;
          cnt_d   = SWRST_CNT_W'(SWRST_CYC - 1);
        end
      end
      ST_SWRST: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1;
        end
      end
      default: begin
        phase_d = ST_FACTORY;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      phase_q <= ST_FACTORY;
      cnt_q   <= '0;
    end else begin
      phase_q <= phase_d;
      cnt_q   <= cnt_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupt: remap change and software reset request events
  logic [IRQ_W-1:0] ist_q;
  logic [IRQ_W-1:0] ien_q;
  logic [IRQ_W-1:0] iev;
  assign iev[IRQ_REMAP_BIT] = wr_map & (reg_wdata[REMAP_BIT] != remap_q);
  assign iev[IRQ_SWRQ_BIT]  = swrst_fire;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ist_q <= '0;
      ien_q <= '0;
    end else begin
      ist_q <= (ist_q & ~({IRQ_W{wr_iclr}} & reg_wdata[IRQ_W-1:0])) | iev;
      if (wr_ien) begin
        ien_q <= reg_wdata[IRQ_W-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read mux and registered outputs
  logic [DATA_W-1:0] rmux;
  always_comb begin
    rmux = '0;
    if (req.rd) begin
      if (hit(req.addr, OFS_MAP_SEL)) begin
        rmux[REMAP_BIT] = remap_q;
      end else if (hit(req.addr, OFS_CAUSE)) begin
        rmux[CAUSE_W-1:0] = cause_q;
      end else if (hit(req.addr, OFS_IRQ_STAT)) begin
        rmux[IRQ_W-1:0] = ist_q;
      end else if (hit(req.addr, OFS_IRQ_EN)) begin
        rmux[IRQ_W-1:0] = ien_q;
      end else if (hit(req.addr, OFS_STATUS)) begin
        rmux[ST_BOOT_BIT] = boot_s;
        rmux[ST_FACT_BIT] = (phase_q == ST_FACTORY);
      end
    end
  end

  // vector region compare on the current fetch
  wire vec_hit = (fetch_addr >= VEC_BASE) && (fetch_addr <= VEC_LAST);
  wire fact_entry = (phase_q == ST_FACTORY) && (phase_d == ST_USER);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata        <= '0;
      sram_at_zero     <= 1'b0;
      in_vector_region <= 1'b0;
      factory_active   <= 1'b1;
      factory_blocked  <= 1'b0;
      start_addr       <= '0;
      start_pulse      <= 1'b0;
      sw_reset_req     <= 1'b0;
      irq              <= 1'b0;
    end else begin
      reg_rdata        <= rmux;
      sram_at_zero     <= remap_d_out(wr_map, reg_wdata[REMAP_BIT], remap_q);
      in_vector_region <= vec_hit;
      factory_active   <= (phase_d == ST_FACTORY);
      // user access to factory area refused
      factory_blocked  <= user_access & (phase_d != ST_FACTORY);
      start_addr       <= RESET_VEC;
      start_pulse      <= fact_entry;
      // request held until the reset controller acts
      sw_reset_req     <= (phase_d == ST_SWRST) && (cnt_d == '0);
      irq              <= |(ist_q & ien_q);
    end
  end

  // next remap value, so the mirror select tracks the write at once
  function automatic logic remap_d_out(input logic w,
                                       input logic v,
                                       input logic cur);
    remap_d_out = w ? v : cur;
  endfunction

endmodule

// File: verilog/rcm_pkg.sv
// package: register map, field layout and types of the reset-cause and remap block
package rcm_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // register offsets (byte addresses, one aligned word each)
  localparam logic [7:0] OFS_MAP_SEL   = 8'h00;
  localparam logic [7:0] OFS_CAUSE     = 8'h04;
  localparam logic [7:0] OFS_CAUSE_CLR = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h0C;
  localparam logic [7:0] OFS_IRQ_CLR   = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN    = 8'h14;
  localparam logic [7:0] OFS_STATUS    = 8'h18;

  // reset cause field positions
  localparam int unsigned CAUSE_POR_BIT = 0;
  localparam int unsigned CAUSE_WDT_BIT = 1;
  localparam int unsigned CAUSE_SW_BIT  = 2;
  localparam int unsigned CAUSE_W       = 8;
  localparam int unsigned REMAP_BIT     = 0;

  // interrupt status field positions
  localparam int unsigned IRQ_REMAP_BIT = 0;
  localparam int unsigned IRQ_SWRQ_BIT  = 1;
  localparam int unsigned IRQ_W         = 2;

  // status register field positions
  localparam int unsigned ST_BOOT_BIT   = 0;
  localparam int unsigned ST_FACT_BIT   = 1;

  // reset values
  localparam logic [CAUSE_W-1:0] CAUSE_RST = 8'h00;
  localparam logic               REMAP_RST = 1'b0;

  // vector region and mirrored base
  localparam logic [31:0] VEC_BASE    = 32'h0000_0000;
  localparam logic [31:0] VEC_LAST    = 32'h0000_0020;
  localparam logic [31:0] RESET_VEC   = 32'h0000_0000;
  localparam logic [31:0] SAFE_BOUND  = 32'h0008_0020;

  // timing: delay before the software reset request is raised
  localparam int unsigned SWRST_NS     = 20;
  localparam int unsigned CLK_PS       = 4000;
  localparam int unsigned SWRST_CYC    = (SWRST_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned SWRST_CNT_W  = 4;

  // register access strobe group
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } rcm_req_s;

  // boot phases after reset
  typedef enum logic [2:0] {
    ST_FACTORY = 3'b001,
    ST_USER    = 3'b010,
    ST_SWRST   = 3'b100
  } rcm_phase_e;

endpackage

// File: tb/rcm_cpu_model.sv
// core-side model: fetch addresses and factory-area probes
module rcm_cpu_model
  import rcm_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic [1:0]  mode,
  output logic      [31:0] fetch_addr,
  output logic             user_access
);
  timeunit 1ns;
  timeprecision 1ps;
  // mode 0 fetches vectors from program memory, others run above base
  always_ff @(posedge sys_clk) begin
    fetch_addr  <= (mode == 2'h0) ? VEC_LAST : SAFE_BOUND;
    user_access <= (mode == 2'h2); // probe of the hidden area
  end
endmodule

// File: tb/rcm_core_sva.sv
// checker: port relations of the reset-cause and remap block
module rcm_core_sva
  import rcm_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              rstn,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [31:0]       fetch_addr,
  input wire logic              user_access,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic              sram_at_zero,
  input wire logic              in_vector_region,
  input wire logic              factory_active,
  input wire logic              factory_blocked,
  input wire logic [31:0]       start_addr,
  input wire logic              start_pulse,
  input wire logic              sw_reset_req
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  property p_rst_map;
    $rose(rstn) |-> !sram_at_zero;
  endproperty
  a_rst_map: assert property (p_rst_map) else $error("map kept");
  property p_map_wr;
    reg_wr && reg_addr == OFS_MAP_SEL |=> sram_at_zero == $past(reg_wdata[0]);
  endproperty
  a_map_wr: assert property (p_map_wr) else $error("map write");
  property p_map_hold;
    !(reg_wr && reg_addr == OFS_MAP_SEL) |=> $stable(sram_at_zero);
  endproperty
  a_map_hold: assert property (p_map_hold) else $error("map drift");
  property p_map_rd;
    reg_rd && reg_addr == OFS_MAP_SEL |=>
      reg_rdata == {31'h0, $past(sram_at_zero)};
  endproperty
  a_map_rd: assert property (p_map_rd) else $error("map read");
  property p_vec;
    $past(rstn) |-> in_vector_region == ($past(fetch_addr) <= VEC_LAST);
  endproperty
  a_vec: assert property (p_vec) else $error("vector region");
  property p_start;
    start_pulse |-> start_addr == RESET_VEC ##1 !start_pulse;
  endproperty
  a_start: assert property (p_start) else $error("start");
  // both outputs are registered from the same next phase
  property p_block;
    $past(rstn) |->
      factory_blocked == ($past(user_access) && !factory_active);
  endproperty
  a_block: assert property (p_block) else $error("hidden area");
  property p_sw_req;
    reg_wr && reg_addr == OFS_CAUSE && reg_wdata[CAUSE_SW_BIT] &&
      !factory_active |-> ##[1:8] sw_reset_req;
  endproperty
  a_sw_req: assert property (p_sw_req) else $error("sw request");
  property p_sw_hold;
    sw_reset_req |=> sw_reset_req;
  endproperty
  a_sw_hold: assert property (p_sw_hold) else $error("sw drop");
endmodule
bind rcm_core rcm_core_sva chk_u (.sys_clk, .rstn, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .fetch_addr, .user_access, .reg_rdata, .sram_at_zero,
  .in_vector_region, .factory_active, .factory_blocked, .start_addr,
  .start_pulse, .sw_reset_req);

// File: tb/rcm_core_tb.sv
// testbench: register scenarios for the reset-cause and remap block
module rcm_core_tb;
  import rcm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 0, rstn = 0, por_n = 0, wdt_timeout = 0;
  logic        boot_select_pin = 1, factory_done = 0, reg_wr = 0, reg_rd = 0;
  logic [1:0]  mode = 0;
  logic [7:0]  reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, start_addr, fetch_addr;
  logic        user_access, sram_at_zero, in_vector_region, factory_active;
  logic        factory_blocked, start_pulse, sw_reset_req, irq;
  int          bad_count = 0, total_checks = 0;
  always #2 sys_clk = ~sys_clk;
  rcm_core dut_u (.sys_clk, .rstn, .por_n, .wdt_timeout, .boot_select_pin,
    .factory_done, .user_access, .fetch_addr, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .sram_at_zero, .in_vector_region, .factory_active,
    .factory_blocked, .start_addr, .start_pulse, .sw_reset_req, .irq);
  rcm_cpu_model cpu_u (.sys_clk, .mode, .fetch_addr, .user_access);
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(string nm, logic [7:0] a, logic [31:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(nm, reg_rdata, exp);
  endtask
  task automatic rst(logic por);
    @(posedge sys_clk);
    rstn <= 1'b0;
    por_n <= ~por;
    factory_done <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    por_n <= 1'b1;
  endtask
  task automatic boot();
    @(posedge sys_clk);
    factory_done <= 1'b1;
    for (int i = 0; i < 20 && start_pulse !== 1'b1; i++) @(negedge sys_clk);
    chk("start", start_pulse, 1'b1);
    chk("start_addr", start_addr, RESET_VEC);
    @(negedge sys_clk);
    chk("phase", factory_active, 1'b0);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // watchdog on a hung run
  initial begin
    #20000;
    bad_count++;
    end_sim();
  end
  // main sequence
  initial begin
    rst(1'b1);
    rd("cause", OFS_CAUSE, 32'h1);
    rd("map", OFS_MAP_SEL, 32'h0);
    boot();
    for (int m = 0; m < 3; m++) begin
      @(posedge sys_clk);
      mode <= m[1:0];
      repeat (3) @(negedge sys_clk);
      chk("vector", in_vector_region, m == 0);
      chk("blocked", factory_blocked, m == 2);
    end
    $display("test boot done");
    wr(OFS_IRQ_EN, 32'h1);
    wr(OFS_MAP_SEL, 32'h1);
    #1 chk("sram", sram_at_zero, 1'b1);
    repeat (2) @(negedge sys_clk);
    chk("irq", irq, 1'b1);
    rd("map", OFS_MAP_SEL, 32'h1);
    wr(OFS_IRQ_CLR, 32'h1);
    repeat (2) @(negedge sys_clk);
    chk("irq", irq, 1'b0);
    wr(OFS_IRQ_EN, 32'h0);
    wr(OFS_MAP_SEL, 32'h0);
    #1 chk("sram", sram_at_zero, 1'b0);
    repeat (2) @(negedge sys_clk);
    chk("irq", irq, 1'b0);
    rd("irq_stat", OFS_IRQ_STAT, 32'h1);
    wr(OFS_MAP_SEL, 32'h1);
    #1 chk("sram", sram_at_zero, 1'b1);
    rd("unmapped", 8'hFC, 32'h0);
    $display("test remap done");
    @(posedge sys_clk);
    wdt_timeout <= 1'b1;
    @(posedge sys_clk);
    wdt_timeout <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd("cause", OFS_CAUSE, 32'h3);
    rst(1'b0);
    #1 chk("sram", sram_at_zero, 1'b0);
    rd("cause", OFS_CAUSE, 32'h3);
    wr(OFS_CAUSE_CLR, 32'h3);
    rd("cause", OFS_CAUSE, 32'h0);
    wr(OFS_CAUSE, 32'h4);
    rd("cause", OFS_CAUSE, 32'h0);
    $display("test watchdog done");
    boot();
    wr(OFS_CAUSE, 32'h4);
    for (int i = 0; i < 20 && sw_reset_req !== 1'b1; i++) @(negedge sys_clk);
    chk("sw_req", sw_reset_req, 1'b1);
    rd("cause", OFS_CAUSE, 32'h4);
    rd("irq_stat", OFS_IRQ_STAT, 32'h2);
    rst(1'b0);
    #1 chk("sw_req", sw_reset_req, 1'b0);
    rd("cause", OFS_CAUSE, 32'h4);
    $display("test software reset done");
    end_sim();
  end
endmodule
